// ---- core/gcnt_consts.svh ----
/*
 * constants of the gated 16-bit counter: register offsets, field positions,
 * reset values and write masks.
 * assumes inclusion by bare name from the design file.
 */
`ifndef GCNT_CONSTS_SVH
`define GCNT_CONSTS_SVH

// word offsets on the register bus
`define GCNT_OFF_CONTROL 8'h00
`define GCNT_OFF_GATE 8'h04
`define GCNT_OFF_COUNT 8'h08
`define GCNT_OFF_IRQ_STATUS 8'h0C
`define GCNT_OFF_IRQ_MASK 8'h10

// counter_control fields
`define GCNT_CTL_RUN 0
`define GCNT_CTL_SYNC_DIS 2
`define GCNT_CTL_OSC_EN 3
`define GCNT_CTL_PRE_LO 4
`define GCNT_CTL_SRC_LO 6
`define GCNT_CTL_WMASK 8'hFD

// counter_gate_control fields
`define GCNT_GT_SRC_LO 0
`define GCNT_GT_LEVEL 2
`define GCNT_GT_ARM 3
`define GCNT_GT_SPM 4
`define GCNT_GT_TOGGLE 5
`define GCNT_GT_POL 6
`define GCNT_GT_EN 7
`define GCNT_GT_WMASK 8'hFB

// interrupt status and mask fields
`define GCNT_IRQ_ROLL 0
`define GCNT_IRQ_GATE 1

// reset values
`define GCNT_RST_CONTROL 8'h00
`define GCNT_RST_GATE 8'h00
`define GCNT_RST_COUNT 16'h0000
`define GCNT_RST_IRQ 2'h0

// instruction clock is the system clock divided by four
`define GCNT_INSTR_DIV_LAST 2'h3

`endif

// ---- core/gcnt_pkg.sv ----
/*
 * types of the gated 16-bit counter.
 * assumes gcnt_consts.svh is on the include path.
 */
package gcnt_pkg;

	// count clock source codes
	typedef enum logic [1:0] {
		GCNT_SRC_INSTR,
		GCNT_SRC_SYS,
		GCNT_SRC_PIN,
		GCNT_SRC_CAP
	} gcnt_src_t;

	// gate source codes
	typedef enum logic [1:0] {
		GCNT_GSRC_PIN,
		GCNT_GSRC_OVF,
		GCNT_GSRC_CMPA,
		GCNT_GSRC_CMPB
	} gcnt_gsrc_t;

endpackage

// ---- core/gcnt_core.sv ----
/*
 * gated 16-bit up-counter with clock source select, prescaler, gate control,
 * toggle and single-pulse gate modes, interrupts and a classic wishbone slave.
 * assumes a single 100 MHz clock; all pins and comparator outputs are
 * asynchronous and pass three flip-flops before use.
 */
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "gcnt_consts.svh"

module gcnt_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic external_count_pin_i,
	input wire logic crystal_clk_i,
	input wire logic capacitive_sense_osc_i,
	input wire logic gate_pin_i,
	input wire logic companion_overflow_i,
	input wire logic comparator_a_sync_out_i,
	input wire logic comparator_b_sync_out_i,
	output logic dedicated_osc_enable_o,
	output logic irq_o,
	output logic [15:0] count_o
);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers

	localparam int NIN = 7;
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] clean_reg;
	logic [NIN-1:0] clean_prev_reg;
	logic [NIN-1:0] clean_rise;
	logic [NIN-1:0] clean_fall;

	assign raw_in = {comparator_b_sync_out_i, comparator_a_sync_out_i, companion_overflow_i,
		gate_pin_i, capacitive_sense_osc_i, crystal_clk_i, external_count_pin_i};

	// three flops per input; the clean level moves only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					clean_reg[gi] <= 1'b0;
					clean_prev_reg[gi] <= 1'b0;
				end else begin
					s1_reg <= raw_in[gi];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						clean_reg[gi] <= s3_reg;
					end
					clean_prev_reg[gi] <= clean_reg[gi];
				end
			end
			assign clean_rise[gi] = clean_reg[gi] & ~clean_prev_reg[gi];
			assign clean_fall[gi] = ~clean_reg[gi] & clean_prev_reg[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0] ctl_reg;
	logic [7:0] gate_reg;
	logic [15:0] count_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;

	gcnt_pkg::gcnt_src_t src_sel;
	gcnt_pkg::gcnt_gsrc_t gsrc_sel;
	logic [1:0] pre_sel;
	logic run_enable;
	logic sync_disable;
	logic gate_enable;
	logic gate_polarity;
	logic gate_toggle_mode;
	logic gate_single_pulse_mode;
	logic single_pulse_arm;

	assign src_sel = gcnt_pkg::gcnt_src_t'(ctl_reg[`GCNT_CTL_SRC_LO +: 2]);
	assign pre_sel = ctl_reg[`GCNT_CTL_PRE_LO +: 2];
	assign run_enable = ctl_reg[`GCNT_CTL_RUN];
	assign sync_disable = ctl_reg[`GCNT_CTL_SYNC_DIS];
	assign gsrc_sel = gcnt_pkg::gcnt_gsrc_t'(gate_reg[`GCNT_GT_SRC_LO +: 2]);
	assign gate_enable = gate_reg[`GCNT_GT_EN];
	assign gate_polarity = gate_reg[`GCNT_GT_POL];
	assign gate_toggle_mode = gate_reg[`GCNT_GT_TOGGLE];
	assign gate_single_pulse_mode = gate_reg[`GCNT_GT_SPM];
	assign single_pulse_arm = gate_reg[`GCNT_GT_ARM];

	logic bus_req;
	logic wr_ctl;
	logic wr_gate;
	logic wr_count;
	logic wr_mask;
	logic rd_status;

	// a request is taken once; the ack of the cycle before blocks a second take
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr_ctl = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `GCNT_OFF_CONTROL);
	assign wr_gate = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `GCNT_OFF_GATE);
	assign wr_count = bus_req & wb_we_i & (wb_adr_i == `GCNT_OFF_COUNT);
	assign wr_mask = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `GCNT_OFF_IRQ_MASK);
	assign rd_status = bus_req & ~wb_we_i & (wb_adr_i == `GCNT_OFF_IRQ_STATUS);

	////////////////////////////////////////////////////////////////////////////
	// count clock selection and prescaler

	logic [1:0] instr_div_reg;
	logic ext_sync_rise_reg;
	logic ext_rise;
	logic src_tick;
	logic [2:0] pre_cnt_reg;
	logic [2:0] pre_last;
	logic pre_tick;

	// free-running divide by four for the instruction clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			instr_div_reg <= 2'h0;
		end else begin
			instr_div_reg <= instr_div_reg + 2'h1;
		end
	end

	// pin or crystal edge; the synchronised path aligns it once more to the clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_sync_rise_reg <= 1'b0;
		end else begin
			ext_sync_rise_reg <= dedicated_osc_enable_o ? clean_rise[1] : clean_rise[0];
		end
	end

	always_comb begin
		ext_rise = dedicated_osc_enable_o ? clean_rise[1] : clean_rise[0];
		if (!sync_disable) begin
			ext_rise = ext_sync_rise_reg;
		end
		unique case (src_sel)
			gcnt_pkg::GCNT_SRC_INSTR: src_tick = (instr_div_reg == `GCNT_INSTR_DIV_LAST);
			gcnt_pkg::GCNT_SRC_SYS: src_tick = 1'b1;
			gcnt_pkg::GCNT_SRC_PIN: src_tick = ext_rise;
			gcnt_pkg::GCNT_SRC_CAP: src_tick = clean_rise[2];
		endcase
	end

	// prescaler passes one tick in 1, 2, 4 or 8
	always_comb begin
		unique case (pre_sel)
			2'h0: pre_last = 3'h0;
			2'h1: pre_last = 3'h1;
			2'h2: pre_last = 3'h3;
			2'h3: pre_last = 3'h7;
		endcase
	end

	assign pre_tick = src_tick & (pre_cnt_reg >= pre_last);

	// prescaler holds at zero while stopped and restarts on any control write
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_enable || wr_ctl) begin
			pre_cnt_reg <= 3'h0;
		end else if (pre_tick) begin
			pre_cnt_reg <= 3'h0;
		end else if (src_tick) begin
			pre_cnt_reg <= pre_cnt_reg + 3'h1;
		end
	end

	// dedicated oscillator follows its enable bit
	assign dedicated_osc_enable_o = ctl_reg[`GCNT_CTL_OSC_EN];

	////////////////////////////////////////////////////////////////////////////
	// gate path

	logic gsrc_level;
	logic gsrc_rise;
	logic toggle_reg;
	logic pol_level;
	logic pol_prev_reg;
	logic pol_rise;
	logic pol_fall;
	logic pulse_open_reg;
	logic gate_level;
	logic gate_level_prev_reg;
	logic count_enable;

	always_comb begin
		unique case (gsrc_sel)
			gcnt_pkg::GCNT_GSRC_PIN: begin
				gsrc_level = clean_reg[3];
				gsrc_rise = clean_rise[3];
			end
			gcnt_pkg::GCNT_GSRC_OVF: begin
				gsrc_level = clean_reg[4];
				gsrc_rise = clean_rise[4];
			end
			gcnt_pkg::GCNT_GSRC_CMPA: begin
				gsrc_level = clean_reg[5];
				gsrc_rise = clean_rise[5];
			end
			gcnt_pkg::GCNT_GSRC_CMPB: begin
				gsrc_level = clean_reg[6];
				gsrc_rise = clean_rise[6];
			end
		endcase
	end

	// toggle flop: flips per rising source edge, held clear outside toggle mode or run
	always_ff @(posedge clk_i) begin
		if (rst_i || !gate_toggle_mode || !run_enable) begin
			toggle_reg <= 1'b0;
		end else if (gsrc_rise) begin
			toggle_reg <= ~toggle_reg;
		end
	end

	// polarity after the optional toggle stage
	assign pol_level = gate_polarity ? (gate_toggle_mode ? toggle_reg : gsrc_level)
		: ~(gate_toggle_mode ? toggle_reg : gsrc_level);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pol_prev_reg <= 1'b0;
		end else begin
			pol_prev_reg <= pol_level;
		end
	end

	assign pol_rise = pol_level & ~pol_prev_reg;
	assign pol_fall = ~pol_level & pol_prev_reg;

	// single pulse: opens on the first active edge after arming, ends on its trailing edge
	always_ff @(posedge clk_i) begin
		if (rst_i || !gate_single_pulse_mode) begin
			pulse_open_reg <= 1'b0;
		end else if (pulse_open_reg && pol_fall) begin
			pulse_open_reg <= 1'b0;
		end else if (single_pulse_arm && pol_rise) begin
			pulse_open_reg <= 1'b1;
		end
	end

	// gate level seen by the counter; in single-pulse mode only the open pulse counts
	assign gate_level = gate_single_pulse_mode ? (pulse_open_reg & pol_level) : pol_level;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_level_prev_reg <= 1'b0;
		end else begin
			gate_level_prev_reg <= gate_level;
		end
	end

	// gate only matters while running and enabled
	assign count_enable = run_enable & (~gate_enable | gate_level);

	////////////////////////////////////////////////////////////////////////////
	// counter

	logic roll_event;
	logic gate_event;

	assign roll_event = count_enable & pre_tick & (count_reg == 16'hFFFF) & ~wr_count;
	assign gate_event = gate_level_prev_reg & ~gate_level;

	// software write of the count wins over an increment in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= `GCNT_RST_COUNT;
		end else if (wr_count) begin
			if (wb_sel_i[0]) begin
				count_reg[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				count_reg[15:8] <= wb_dat_i[15:8];
			end
		end else if (count_enable && pre_tick) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	assign count_o = count_reg;

	////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_reg <= `GCNT_RST_CONTROL;
		end else if (wr_ctl) begin
			ctl_reg <= wb_dat_i[7:0] & `GCNT_CTL_WMASK;
		end
	end

	// arm bit: software sets it, hardware clears it at the end of the pulse and holds it clear outside single-pulse mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_reg <= `GCNT_RST_GATE;
		end else if (wr_gate) begin
			gate_reg <= wb_dat_i[7:0] & `GCNT_GT_WMASK;
		end else if (!gate_single_pulse_mode || (pulse_open_reg && pol_fall)) begin
			gate_reg[`GCNT_GT_ARM] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts

	// events set sticky bits; a status read clears them, a new event in that cycle stays
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_reg <= `GCNT_RST_IRQ;
		end else begin
			irq_status_reg[`GCNT_IRQ_ROLL] <= roll_event
				| (irq_status_reg[`GCNT_IRQ_ROLL] & ~rd_status);
			irq_status_reg[`GCNT_IRQ_GATE] <= gate_event
				| (irq_status_reg[`GCNT_IRQ_GATE] & ~rd_status);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= `GCNT_RST_IRQ;
		end else if (wr_mask) begin
			irq_mask_reg <= wb_dat_i[1:0];
		end
	end

	assign irq_o = |(irq_status_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////////
	// wishbone answer

	// ack one cycle after the request is seen; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req;
			if (bus_req && !wb_we_i) begin
				unique case (wb_adr_i)
					`GCNT_OFF_CONTROL: rdata_reg <= {24'h000000, ctl_reg};
					`GCNT_OFF_GATE: rdata_reg <= {24'h000000, gate_reg[7:3],
						gate_level, gate_reg[1:0]};
					`GCNT_OFF_COUNT: rdata_reg <= {16'h0000, count_reg};
					`GCNT_OFF_IRQ_STATUS: rdata_reg <= {30'h00000000, irq_status_reg};
					`GCNT_OFF_IRQ_MASK: rdata_reg <= {30'h00000000, irq_mask_reg};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

endmodule

// ---- testbench/gcnt_core_properties.sv ----
/* port checker of the gated counter core.
   assumes one clock domain and a bind to gcnt_core. */
`timescale 1ns/1ns
module gcnt_core_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic gate_pin_i,
	input wire logic dedicated_osc_enable_o,
	input wire logic irq_o,
	input wire logic [15:0] count_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	logic tk;
	logic [7:0] ctl_q;
	logic [7:0] gt_q;
	logic [1:0] msk_q;
	// a request is taken while ack is low
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// shadow copies of the writable control fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_q <= 8'h00;
			gt_q <= 8'h00;
			msk_q <= 2'h0;
		end else if (tk && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == 8'h00) ctl_q <= wb_dat_i[7:0] & 8'hFD;
			if (wb_adr_i == 8'h04) gt_q <= wb_dat_i[7:0];
			if (wb_adr_i == 8'h10) msk_q <= wb_dat_i[1:0];
		end
	end
	////////////////////////////////////////////////////////////////
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_ack_next;
		tk |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_osc;
		(tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00) |=>
			dedicated_osc_enable_o == $past(wb_dat_i[3]);
	endproperty
	a_osc: assert property (p_osc) else $error("osc enable wrong");
	property p_unmap;
		(tk && !wb_we_i && wb_adr_i == 8'h14) |=> wb_dat_o == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_hold;
		(!ctl_q[0] && !tk)[*3] |-> $stable(count_o);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved while stopped");
	property p_step;
		($changed(count_o) && !$past(tk && wb_we_i)) |-> count_o == $past(count_o) + 16'h1;
	endproperty
	a_step: assert property (p_step) else $error("count step wrong");
	property p_sys;
		(ctl_q[7:4] == 4'h4 && ctl_q[0] && !gt_q[7] && !tk)[*4] |->
			count_o == $past(count_o) + 16'h1;
	endproperty
	a_sys: assert property (p_sys) else $error("system clock rate wrong");
	property p_pre8;
		(ctl_q[7:4] == 4'h7 && ctl_q[0] && !tk && $changed(count_o)) |=>
			(!$changed(count_o) || $past(tk))[*7];
	endproperty
	a_pre8: assert property (p_pre8) else $error("prescale 8 wrong");
	property p_gate;
		(!gate_pin_i && gt_q == 8'hC0 && !tk)[*8] |-> $stable(count_o);
	endproperty
	a_gate: assert property (p_gate) else $error("closed gate counted");
	property p_irq;
		(msk_q == 2'h0)[*2] |-> !irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("masked irq raised");
	c_roll: cover property ($past(count_o) == 16'hFFFF && count_o == 16'h0000);
	c_irq: cover property ($rose(irq_o));
	c_gate: cover property ((!gate_pin_i && gt_q == 8'hC0 && !tk)[*8]);
endmodule

bind gcnt_core gcnt_core_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .gate_pin_i,
	.dedicated_osc_enable_o, .irq_o, .count_o);

// ---- testbench/gcnt_far_model.sv ----
/* far side: count pin, crystal, sense oscillator and gate sources.
   assumes the bench sets the gate source levels. */
`timescale 1ns/1ns
module gcnt_far_model (
	input wire logic clk_i,
	input wire logic osc_en_i,
	input wire logic [3:0] lvl_i,
	output logic pin_o,
	output logic xtal_o,
	output logic cap_o,
	output logic [3:0] gsrc_o
);
	logic [2:0] n = 3'h0;
	logic [3:0] m = 4'h0;
	logic x = 1'h0;
	// pin period 8, crystal 16 only while enabled, sense oscillator 12
	always_ff @(posedge clk_i) begin
		n <= n + 3'h1;
		m <= (m == 4'hB) ? 4'h0 : m + 4'h1;
		if (n == 3'h7) x <= osc_en_i ? !x : 1'h0;
	end
	assign pin_o = n[2];
	assign xtal_o = x;
	assign cap_o = m < 4'h6;
	assign gsrc_o = lvl_i;
endmodule

// ---- testbench/tb.sv ----
/* bench of the gated counter core: bus tasks and scenarios.
   assumes the far side model drives every pin input. */
`timescale 1ns/1ns
module tb;
	logic clk_i;
	logic rst_i;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic external_count_pin_i;
	logic crystal_clk_i;
	logic capacitive_sense_osc_i;
	logic gate_pin_i;
	logic companion_overflow_i;
	logic comparator_a_sync_out_i;
	logic comparator_b_sync_out_i;
	logic dedicated_osc_enable_o;
	logic irq_o;
	logic [15:0] count_o;
	logic [3:0] lv;
	logic [31:0] rd;
	logic [31:0] c;
	int fails;
	int comparisons;
	int cycles;
	logic [7:0] ctab [14] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h51, 8'h61, 8'h71,
		8'h45, 8'h81, 8'h85, 8'h89, 8'h8D, 8'hC1};
	int dtab [14] = '{4, 8, 16, 32, 1, 2, 4, 8, 1, 8, 8, 16, 16, 12};
	////////////////////////////////////////////////////////////////
	gcnt_core dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .external_count_pin_i, .crystal_clk_i,
		.capacitive_sense_osc_i, .gate_pin_i, .companion_overflow_i,
		.comparator_a_sync_out_i, .comparator_b_sync_out_i, .dedicated_osc_enable_o,
		.irq_o, .count_o);
	gcnt_far_model far (.clk_i, .osc_en_i(dedicated_osc_enable_o), .lvl_i(lv),
		.pin_o(external_count_pin_i), .xtal_o(crystal_clk_i), .cap_o(capacitive_sense_osc_i),
		.gsrc_o({comparator_b_sync_out_i, comparator_a_sync_out_i, companion_overflow_i,
		gate_pin_i}));
	////////////////////////////////////////////////////////////////
	// one classic wishbone cycle, read data left in rd
	// waits for ack however long it takes; only the hang guard ends a stuck wait
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	// compare within a tolerance t
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] t,
		input logic [31:0] g);
		comparisons++;
		if ((g + t >= e && g <= e + t) !== 1'h1) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", s, e, g);
		end
	endtask
	// count for w cycles with the given setup, then stop
	task automatic meas(input logic [7:0] ctl, input logic [7:0] gt, input int w);
		bus(8'h08, 1'h1, 32'h0);
		bus(8'h04, 1'h1, {24'h0, gt});
		bus(8'h00, 1'h1, {24'h0, ctl});
		repeat (w) @(posedge clk_i);
		bus(8'h00, 1'h1, 32'h0);
		bus(8'h08, 1'h0, 32'h0);
		c = rd;
		repeat (10) @(posedge clk_i);
		bus(8'h08, 1'h0, 32'h0);
		chk("stopped count", c, 0, rd);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			bus(8'(i * 4), 1'h0, 32'h0);
			chk("reset value", 32'h0, 0, rd & 32'hFFFFFFFB);
		end
		bus(8'h14, 1'h1, 32'hFF);
		bus(8'h14, 1'h0, 32'h0);
		chk("unmapped", 32'h0, 0, rd);
		bus(8'h00, 1'h1, 32'hFF);
		bus(8'h00, 1'h0, 32'h0);
		chk("control", 32'hFD, 0, rd);
		chk("osc on", 1, 0, dedicated_osc_enable_o);
		bus(8'h00, 1'h1, 32'h0);
		chk("osc off", 0, 0, dedicated_osc_enable_o);
	endtask
	task automatic t_rates();
		for (int i = 0; i < 14; i++) begin
			meas(ctab[i], 8'h00, 160);
			chk("rate", 32'(163 / dtab[i]), 2, c);
		end
	endtask
	task automatic t_gates();
		for (int g = 0; g < 4; g++) begin
			for (int v = 0; v < 2; v++) begin
				lv <= v ? 4'(1 << g) : 4'h0;
				meas(8'h41, 8'hC0 | 8'(g), 40);
				chk("gated", v ? 43 : 0, 3, c);
				bus(8'h04, 1'h0, 32'h0);
				chk("level", 32'(v), 0, rd[2]);
			end
		end
		meas(8'h41, 8'h40, 20);
		chk("ungated", 23, 3, c);
		lv <= 4'h0;
		meas(8'h41, 8'h80, 20);
		chk("active low", 23, 3, c);
	endtask
	task automatic t_event();
		bus(8'h04, 1'h1, 32'h40);
		repeat (8) @(posedge clk_i);
		bus(8'h0C, 1'h0, 32'h0);
		bus(8'h10, 1'h1, 32'h3);
		lv <= 4'h1;
		repeat (10) @(posedge clk_i);
		chk("irq idle", 0, 0, irq_o);
		lv <= 4'h0;
		repeat (10) @(posedge clk_i);
		chk("irq event", 1, 0, irq_o);
		bus(8'h0C, 1'h0, 32'h0);
		chk("status", 32'h2, 0, rd);
		bus(8'h0C, 1'h0, 32'h0);
		chk("status cleared", 32'h0, 0, rd);
		chk("irq cleared", 0, 0, irq_o);
	endtask
	task automatic t_toggle();
		bus(8'h08, 1'h1, 32'h0);
		bus(8'h04, 1'h1, 32'hE0);
		bus(8'h00, 1'h1, 32'h41);
		lv <= 4'h1;
		repeat (10) @(posedge clk_i);
		lv <= 4'h0;
		repeat (30) @(posedge clk_i);
		bus(8'h08, 1'h0, 32'h0);
		c = rd;
		repeat (20) @(posedge clk_i);
		bus(8'h08, 1'h0, 32'h0);
		chk("toggle open", c + 23, 4, rd);
		lv <= 4'h1;
		repeat (10) @(posedge clk_i);
		bus(8'h08, 1'h0, 32'h0);
		c = rd;
		repeat (20) @(posedge clk_i);
		bus(8'h08, 1'h0, 32'h0);
		chk("toggle closed", c, 0, rd);
		// reopen the toggle gate, then drop and restore toggle mode: flop must restart clear
		lv <= 4'h0;
		repeat (10) @(posedge clk_i);
		lv <= 4'h1;
		repeat (10) @(posedge clk_i);
		bus(8'h04, 1'h1, 32'hC0);
		bus(8'h04, 1'h1, 32'hE0);
		bus(8'h08, 1'h0, 32'h0);
		c = rd;
		repeat (20) @(posedge clk_i);
		bus(8'h08, 1'h0, 32'h0);
		chk("toggle cleared", c, 0, rd);
	endtask
	task automatic t_pulse();
		lv <= 4'h0;
		bus(8'h00, 1'h1, 32'h0);
		bus(8'h08, 1'h1, 32'h0);
		bus(8'h04, 1'h1, 32'hD8);
		bus(8'h00, 1'h1, 32'h41);
		bus(8'h04, 1'h0, 32'h0);
		chk("armed", 1, 0, rd[3]);
		lv <= 4'h1;
		repeat (30) @(posedge clk_i);
		lv <= 4'h0;
		repeat (10) @(posedge clk_i);
		bus(8'h04, 1'h0, 32'h0);
		chk("arm done", 0, 0, rd[3]);
		bus(8'h08, 1'h0, 32'h0);
		chk("pulse count", 30, 4, rd);
		c = rd;
		lv <= 4'h1;
		repeat (20) @(posedge clk_i);
		lv <= 4'h0;
		repeat (10) @(posedge clk_i);
		bus(8'h08, 1'h0, 32'h0);
		chk("second pulse", c, 0, rd);
	endtask
	task automatic t_roll();
		bus(8'h00, 1'h1, 32'h0);
		bus(8'h08, 1'h1, 32'hFFFE);
		bus(8'h08, 1'h0, 32'h0);
		chk("count write", 32'hFFFE, 0, rd);
		bus(8'h0C, 1'h0, 32'h0);
		bus(8'h04, 1'h1, 32'h0);
		bus(8'h00, 1'h1, 32'h41);
		repeat (10) @(posedge clk_i);
		bus(8'h00, 1'h1, 32'h0);
		chk("irq roll", 1, 0, irq_o);
		bus(8'h0C, 1'h0, 32'h0);
		chk("roll flag", 1, 0, rd[0]);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		rst_i = 1'h1;
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i = 1'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		lv = 4'h0;
		fails = 0;
		comparisons = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		t_regs();
		t_rates();
		t_gates();
		t_event();
		t_toggle();
		t_pulse();
		t_roll();
		print_verdict();
	end
endmodule
